// >>> lpfc_pkg.sv
// Constants, types and helpers for the line printer format control block
// What this block does
// - Row interrupt at each row point start
// - Local switch enables row interrupts too
// - Ten-position format count with per-position settings
// - Hold keeps host spacing until skip-advance
// - Transition cycle feeds host spacing: zero to three spaces, nine on jump
// - Advance position feeds then increments count
// - Consecutive advance positions step automatically
// - Clear position increments without feeding paper
// - Home position always acts as hold
// - Host spacing uses space setting only
// - Format spacing multiplies by three when on
// - Stop-paper suppresses unmultiplied format feeds
// - Jump feeds nine spaces under host
// - Stop-paper suppresses host feed, print continues
// - Two-second clear input returns count home
// - Fifteen points per cycle, eleven row points
// - Function word bit positions decoded
// - Missing first field write flags fault
package lpfc_pkg;
	localparam int CLK_PERIOD_NS = 50;
	localparam int T_POINT_US = 26670;
	localparam int T_FW_DEADLINE_US = 1500;
	localparam int T_CLR_HOLD_MS = 2000;
	localparam int POINT_CYC = T_POINT_US * 1000 / CLK_PERIOD_NS;
	localparam int FW_DEADLINE_CYC = T_FW_DEADLINE_US * 1000 / CLK_PERIOD_NS;
	localparam int CLR_HOLD_CYC = (T_CLR_HOLD_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam logic [3:0] LAST_PT = 4'he;
	localparam logic [3:0] LAST_ROW_PT = 4'ha;
	localparam logic [3:0] FIRST_PT = 4'h0;
	localparam logic [3:0] LAST_POS = 4'h9;
	localparam logic [3:0] HOME_POS = 4'h0;
	localparam logic [3:0] JUMP_SPACES = 4'h9;

	localparam int FB_START = 34;
	localparam int FB_JUMP = 13;
	localparam int FB_SKIP = 12;
	localparam int FB_IRQ = 11;
	localparam int FB_PRINT = 10;
	localparam int FB_STOP = 9;

	localparam logic [7:0] REG_FUNC_LO = 8'h00;
	localparam logic [7:0] REG_FUNC_HI = 8'h04;
	localparam logic [7:0] REG_FIELD = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam int ST_BUSY = 0;
	localparam int ST_FAULT = 1;
	localparam int ST_FMT = 2;
	localparam int ST_CNT_LSB = 4;
	localparam int ST_PT_LSB = 8;
	localparam int ST_FW_LSB = 12;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		CTL_HOLD = 2'h0,
		CTL_ADVANCE = 2'h1,
		CTL_CLEAR = 2'h2
	} lpfc_ctl_e;

	typedef enum logic [1:0] {
		MD_HOST = 2'b01,
		MD_FMT = 2'b10
	} lpfc_mode_e;

	function automatic lpfc_ctl_e lpfc_eff_ctl(input logic [19:0] ctl, input logic [3:0] pos);
		logic [1:0] code;
		code = ctl[pos * 2 +: 2];
		if (pos == HOME_POS || pos > LAST_POS) begin
			return CTL_HOLD;
		end
		if (code == CTL_ADVANCE) begin
			return CTL_ADVANCE;
		end
		if (code == CTL_CLEAR) begin
			return CTL_CLEAR;
		end
		return CTL_HOLD;
	endfunction

	function automatic logic [3:0] lpfc_next_pos(input logic [3:0] pos);
		return (pos >= LAST_POS) ? HOME_POS : pos + 4'h1;
	endfunction
endpackage

// >>> lpfc_seq_if.sv
// Signals shared between the control core, point sequencer and clear timer
`timescale 1ns/1ps
interface lpfc_seq_if;
	logic start;
	logic active;
	logic pt_start;
	logic cyc_end;
	logic clr_hold;
	logic [3:0] pt_idx;
	modport seq(input start, output active, output pt_start, output cyc_end, output pt_idx);
	modport clr(output clr_hold);
	modport ctl(output start, input active, input pt_start, input cyc_end, input pt_idx,
		input clr_hold);
endinterface

// >>> lpfc_point_seq.sv
// Printer cycle timer: fifteen points, row points first
`timescale 1ns/1ps
module lpfc_point_seq
	import lpfc_pkg::*;
#(
	parameter int unsigned POINT_CYC_P = POINT_CYC
) (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	lpfc_seq_if.seq sq
);
	logic active_r, active_nxt;
	logic pt_start_r, pt_start_nxt;
	logic cyc_end_r, cyc_end_nxt;
	logic [3:0] idx_r, idx_nxt;
	logic [19:0] tick_r, tick_nxt;

	always_comb begin
		active_nxt = active_r;
		idx_nxt = idx_r;
		tick_nxt = tick_r;
		pt_start_nxt = 1'b0;
		cyc_end_nxt = 1'b0;
		if (!active_r) begin
			if (sq.start) begin
				active_nxt = 1'b1;
				idx_nxt = FIRST_PT;
				tick_nxt = 20'h0;
				pt_start_nxt = 1'b1;
			end
		end else if (tick_r == 20'(POINT_CYC_P - 1)) begin
			tick_nxt = 20'h0;
			if (idx_r == LAST_PT) begin
				active_nxt = 1'b0;
				cyc_end_nxt = 1'b1;
			end else begin
				idx_nxt = idx_r + 4'h1;
				pt_start_nxt = 1'b1;
			end
		end else begin
			tick_nxt = tick_r + 20'h1;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			active_r <= 1'b0;
			idx_r <= FIRST_PT;
			tick_r <= 20'h0;
			pt_start_r <= 1'b0;
			cyc_end_r <= 1'b0;
		end else begin
			active_r <= active_nxt;
			idx_r <= idx_nxt;
			tick_r <= tick_nxt;
			pt_start_r <= pt_start_nxt;
			cyc_end_r <= cyc_end_nxt;
		end
	end

	assign sq.active = active_r;
	assign sq.pt_start = pt_start_r;
	assign sq.cyc_end = cyc_end_r;
	assign sq.pt_idx = idx_r;

	AST_CYC_END: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		sq.cyc_end |-> ($past(idx_r) == LAST_PT && !active_r))
		else $error("cycle ended away from the last point");
	AST_PT_RANGE: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		sq.pt_start |-> (active_r && idx_r <= LAST_PT && tick_r == 20'h0))
		else $error("point start outside the fifteen points");
endmodule

// >>> lpfc_clr_hold.sv
// Clear-control input: synchronised, must stay high for the full hold time
`timescale 1ns/1ps
module lpfc_clr_hold
	import lpfc_pkg::*;
#(
	parameter int unsigned HOLD_CYC_P = CLR_HOLD_CYC
) (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic i_clear_ctl,
	lpfc_seq_if.clr cl
);
	logic sync1_r, sync2_r;
	logic [25:0] cnt_r, cnt_nxt;
	logic done_r, done_nxt;
	logic pulse_r, pulse_nxt;

	always_comb begin
		cnt_nxt = cnt_r;
		done_nxt = done_r;
		pulse_nxt = 1'b0;
		if (!sync2_r) begin
			cnt_nxt = 26'h0;
			done_nxt = 1'b0;
		end else if (!done_r) begin
			if (cnt_r == 26'(HOLD_CYC_P - 1)) begin
				done_nxt = 1'b1;
				pulse_nxt = 1'b1;
			end else begin
				cnt_nxt = cnt_r + 26'h1;
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			cnt_r <= 26'h0;
			done_r <= 1'b0;
			pulse_r <= 1'b0;
		end else begin
			sync1_r <= i_clear_ctl;
			sync2_r <= sync1_r;
			cnt_r <= cnt_nxt;
			done_r <= done_nxt;
			pulse_r <= pulse_nxt;
		end
	end

	assign cl.clr_hold = pulse_r;

	AST_CLR_ONCE: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		cl.clr_hold |-> ($past(sync2_r) && $past(cnt_r) == 26'(HOLD_CYC_P - 1)) ##1 !cl.clr_hold)
		else $error("clear pulse without full hold or repeated");
endmodule

// >>> lpfc_top.sv
// Line printer sequencer and format spacing control with AXI4-Lite registers
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module lpfc_top #(
	parameter int unsigned POINT_CYC_P = lpfc_pkg::POINT_CYC,
	parameter int unsigned FW_DEADLINE_CYC_P = lpfc_pkg::FW_DEADLINE_CYC,
	parameter int unsigned CLR_HOLD_CYC_P = lpfc_pkg::CLR_HOLD_CYC
) (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic [7:0] i_s_axi_awaddr,
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	output logic [1:0] o_s_axi_bresp,
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	input wire logic [7:0] i_s_axi_araddr,
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	input wire logic [19:0] i_fmt_ctl,
	input wire logic [19:0] i_fmt_space,
	input wire logic [9:0] i_fmt_mult,
	input wire logic i_irq_switch,
	input wire logic i_clear_ctl,
	output logic o_row_irq,
	output logic o_feed_valid,
	output logic [3:0] o_feed_spaces,
	output logic o_field_valid,
	output logic [31:0] o_field_data,
	output logic o_fault,
	output logic o_busy,
	output logic [3:0] o_fmt_count
);
	import lpfc_pkg::*;

	lpfc_seq_if sq();

	lpfc_point_seq #(.POINT_CYC_P(POINT_CYC_P)) u_seq (
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.sq(sq.seq)
	);

	lpfc_clr_hold #(.HOLD_CYC_P(CLR_HOLD_CYC_P)) u_clr (
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.i_clear_ctl(i_clear_ctl),
		.cl(sq.clr)
	);

	// Switchboard settings are pins; two stages before use
	logic [50:0] cfg_s1_r, cfg_s2_r;
	logic [19:0] ctl_s, space_s;
	logic [9:0] mult_s;
	logic irq_sw_s;
	assign {irq_sw_s, mult_s, space_s, ctl_s} = cfg_s2_r;

	// Bus slave state
	logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
	logic [7:0] aw_addr_r, aw_addr_nxt;
	logic [31:0] w_data_r, w_data_nxt;
	logic [3:0] w_strb_r, w_strb_nxt;
	logic awready_r, awready_nxt, wready_r, wready_nxt;
	logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [31:0] rdata_r, rdata_nxt;

	// Core state
	lpfc_mode_e mode_r, mode_nxt;
	logic [3:0] func_hi_r, func_hi_nxt;
	logic pend_r, pend_nxt;
	logic [35:0] pend_word_r, pend_word_nxt;
	logic stop_fmt_r, stop_fmt_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic start_r, start_nxt;
	logic cyc_print_r, cyc_print_nxt, cyc_irq_r, cyc_irq_nxt;
	logic cyc_jump_r, cyc_jump_nxt, cyc_mult_r, cyc_mult_nxt, cyc_clr_r, cyc_clr_nxt;
	logic [3:0] feed_amt_r, feed_amt_nxt, feed_spaces_r, feed_spaces_nxt;
	logic feed_valid_r, feed_valid_nxt, irq_r, irq_nxt, fault_r, fault_nxt;
	logic dl_run_r, dl_run_nxt;
	logic [14:0] dl_tick_r, dl_tick_nxt;
	logic [1:0] fw_cnt_r, fw_cnt_nxt;
	logic field_stb_r, field_stb_nxt;
	logic [31:0] field_data_r, field_data_nxt;

	logic do_wr, fw_evt, dl_expire;
	logic [35:0] word;
	logic [1:0] sp;
	logic [3:0] sp1, sp3;
	lpfc_ctl_e ctl_here;

	assign do_wr = aw_have_r && w_have_r && !bvalid_r;
	assign fw_evt = do_wr && aw_addr_r == REG_FIELD;
	assign dl_expire = dl_run_r && dl_tick_r == 15'(FW_DEADLINE_CYC_P - 1);
	assign sp = space_s[cnt_r * 2 +: 2];
	assign sp1 = {2'h0, sp};
	assign sp3 = {1'b0, sp, 1'b0} + sp1;
	assign ctl_here = lpfc_eff_ctl(ctl_s, cnt_r);

	always_comb begin
		aw_have_nxt = aw_have_r;
		aw_addr_nxt = aw_addr_r;
		w_have_nxt = w_have_r;
		w_data_nxt = w_data_r;
		w_strb_nxt = w_strb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		arready_nxt = 1'b0;
		rvalid_nxt = rvalid_r;
		rresp_nxt = rresp_r;
		rdata_nxt = rdata_r;
		mode_nxt = mode_r;
		func_hi_nxt = func_hi_r;
		pend_nxt = pend_r;
		pend_word_nxt = pend_word_r;
		stop_fmt_nxt = stop_fmt_r;
		cnt_nxt = cnt_r;
		start_nxt = 1'b0;
		cyc_print_nxt = cyc_print_r;
		cyc_irq_nxt = cyc_irq_r;
		cyc_jump_nxt = cyc_jump_r;
		cyc_mult_nxt = cyc_mult_r;
		cyc_clr_nxt = cyc_clr_r;
		feed_amt_nxt = feed_amt_r;
		fault_nxt = fault_r;
		dl_run_nxt = dl_run_r;
		dl_tick_nxt = dl_tick_r;
		fw_cnt_nxt = fw_cnt_r;
		field_stb_nxt = 1'b0;
		field_data_nxt = field_data_r;
		word = {func_hi_r, w_data_r};

		// Address and data may arrive in either order; each is held until both are in
		if (awready_r && i_s_axi_awvalid) begin
			aw_have_nxt = 1'b1;
			aw_addr_nxt = i_s_axi_awaddr;
		end
		if (wready_r && i_s_axi_wvalid) begin
			w_have_nxt = 1'b1;
			w_data_nxt = i_s_axi_wdata;
			w_strb_nxt = i_s_axi_wstrb;
		end
		if (bvalid_r && i_s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		if (do_wr) begin
			aw_have_nxt = 1'b0;
			w_have_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = RESP_OKAY;
			unique case (aw_addr_r)
				REG_FUNC_LO: begin
					if (word[FB_START]) begin
						pend_nxt = 1'b1;
						pend_word_nxt = word;
					end
				end
				REG_FUNC_HI: begin
					if (w_strb_r[0]) begin
						func_hi_nxt = w_data_r[3:0];
					end
				end
				REG_FIELD: begin
					field_stb_nxt = 1'b1;
					field_data_nxt = w_data_r;
				end
				REG_STATUS: begin
					if (w_strb_r[0] && w_data_r[ST_FAULT]) begin
						fault_nxt = 1'b0;
					end
				end
				default: bresp_nxt = RESP_SLVERR;
			endcase
		end
		awready_nxt = !aw_have_nxt && !bvalid_nxt;
		wready_nxt = !w_have_nxt && !bvalid_nxt;

		if (rvalid_r && i_s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
		if (!rvalid_r && !arready_r && i_s_axi_arvalid) begin
			arready_nxt = 1'b1;
		end
		if (arready_r && i_s_axi_arvalid) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = RESP_OKAY;
			rdata_nxt = 32'h0;
			unique case (i_s_axi_araddr)
				REG_FUNC_LO, REG_FIELD: rdata_nxt = 32'h0;
				REG_FUNC_HI: rdata_nxt = {28'h0, func_hi_r};
				REG_STATUS: begin
					rdata_nxt[ST_BUSY] = sq.active;
					rdata_nxt[ST_FAULT] = fault_r;
					rdata_nxt[ST_FMT] = mode_r == MD_FMT;
					rdata_nxt[ST_CNT_LSB +: 4] = cnt_r;
					rdata_nxt[ST_PT_LSB +: 4] = sq.pt_idx;
					rdata_nxt[ST_FW_LSB +: 2] = fw_cnt_r;
				end
				default: rresp_nxt = RESP_SLVERR;
			endcase
		end

		// Deadline for the first field write of each sensed row
		if (fw_evt && fw_cnt_r != 2'h3) begin
			fw_cnt_nxt = fw_cnt_r + 2'h1;
		end
		if (dl_run_r) begin
			dl_tick_nxt = dl_tick_r + 15'h1;
			if (fw_evt) begin
				dl_run_nxt = 1'b0;
			end else if (dl_expire) begin
				dl_run_nxt = 1'b0;
				fault_nxt = 1'b1;
			end
		end
		if (sq.pt_start) begin
			fw_cnt_nxt = 2'h0;
			dl_tick_nxt = 15'h0;
			dl_run_nxt = cyc_print_r && sq.pt_idx <= LAST_ROW_PT;
		end

		// A faulted printer finishes its cycle, then no new cycle starts
		if (!sq.active && !start_r && !fault_r) begin
			if (mode_r == MD_FMT) begin
				if (ctl_here == CTL_HOLD) begin
					mode_nxt = MD_HOST;
				end else begin
					start_nxt = 1'b1;
					cyc_print_nxt = 1'b0;
					cyc_irq_nxt = 1'b0;
					cyc_jump_nxt = 1'b0;
					cyc_clr_nxt = ctl_here == CTL_CLEAR;
					cyc_mult_nxt = ctl_here == CTL_ADVANCE && i_fmt_mult_sel(mult_s, cnt_r);
					cnt_nxt = lpfc_next_pos(cnt_r);
					if (ctl_here == CTL_CLEAR) begin
						feed_amt_nxt = 4'h0;
					end else if (mult_s[cnt_r]) begin
						feed_amt_nxt = sp3;
					end else begin
						feed_amt_nxt = stop_fmt_r ? 4'h0 : sp1;
					end
				end
			end else if (pend_r) begin
				pend_nxt = 1'b0;
				start_nxt = 1'b1;
				cyc_print_nxt = pend_word_r[FB_PRINT];
				cyc_irq_nxt = pend_word_r[FB_PRINT] && (pend_word_r[FB_IRQ] || irq_sw_s);
				cyc_jump_nxt = pend_word_r[FB_JUMP];
				cyc_mult_nxt = 1'b0;
				cyc_clr_nxt = 1'b0;
				if (pend_word_r[FB_JUMP]) begin
					feed_amt_nxt = JUMP_SPACES;
				end else if (pend_word_r[FB_STOP]) begin
					feed_amt_nxt = 4'h0;
				end else begin
					feed_amt_nxt = sp1;
				end
				if (pend_word_r[FB_SKIP] &&
					lpfc_eff_ctl(ctl_s, lpfc_next_pos(cnt_r)) == CTL_ADVANCE) begin
					mode_nxt = MD_FMT;
					stop_fmt_nxt = pend_word_r[FB_STOP];
					cnt_nxt = lpfc_next_pos(cnt_r);
				end
			end
		end
		if (sq.clr_hold) begin
			cnt_nxt = HOME_POS;
			mode_nxt = MD_HOST;
			start_nxt = 1'b0;
		end
		// Hardware-set fault wins over a software clear in the same cycle
		if (dl_run_r && !fw_evt && dl_expire) begin
			fault_nxt = 1'b1;
		end

		irq_nxt = sq.pt_start && sq.pt_idx <= LAST_ROW_PT && cyc_irq_r;
		feed_valid_nxt = sq.pt_start && sq.pt_idx == FIRST_PT;
		feed_spaces_nxt = feed_valid_nxt ? feed_amt_r : feed_spaces_r;
	end

	function automatic logic i_fmt_mult_sel(input logic [9:0] m, input logic [3:0] pos);
		return m[pos];
	endfunction

	assign sq.start = start_r;

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cfg_s1_r <= 51'h0;
			cfg_s2_r <= 51'h0;
			aw_have_r <= 1'b0;
			aw_addr_r <= 8'h0;
			w_have_r <= 1'b0;
			w_data_r <= 32'h0;
			w_strb_r <= 4'h0;
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rresp_r <= RESP_OKAY;
			rdata_r <= 32'h0;
			mode_r <= MD_HOST;
			func_hi_r <= 4'h0;
			pend_r <= 1'b0;
			pend_word_r <= 36'h0;
			stop_fmt_r <= 1'b0;
			cnt_r <= HOME_POS;
			start_r <= 1'b0;
			cyc_print_r <= 1'b0;
			cyc_irq_r <= 1'b0;
			cyc_jump_r <= 1'b0;
			cyc_mult_r <= 1'b0;
			cyc_clr_r <= 1'b0;
			feed_amt_r <= 4'h0;
			feed_spaces_r <= 4'h0;
			feed_valid_r <= 1'b0;
			irq_r <= 1'b0;
			fault_r <= 1'b0;
			dl_run_r <= 1'b0;
			dl_tick_r <= 15'h0;
			fw_cnt_r <= 2'h0;
			field_stb_r <= 1'b0;
			field_data_r <= 32'h0;
		end else begin
			cfg_s1_r <= {i_irq_switch, i_fmt_mult, i_fmt_space, i_fmt_ctl};
			cfg_s2_r <= cfg_s1_r;
			aw_have_r <= aw_have_nxt;
			aw_addr_r <= aw_addr_nxt;
			w_have_r <= w_have_nxt;
			w_data_r <= w_data_nxt;
			w_strb_r <= w_strb_nxt;
			awready_r <= awready_nxt;
			wready_r <= wready_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			arready_r <= arready_nxt;
			rvalid_r <= rvalid_nxt;
			rresp_r <= rresp_nxt;
			rdata_r <= rdata_nxt;
			mode_r <= mode_nxt;
			func_hi_r <= func_hi_nxt;
			pend_r <= pend_nxt;
			pend_word_r <= pend_word_nxt;
			stop_fmt_r <= stop_fmt_nxt;
			cnt_r <= cnt_nxt;
			start_r <= start_nxt;
			cyc_print_r <= cyc_print_nxt;
			cyc_irq_r <= cyc_irq_nxt;
			cyc_jump_r <= cyc_jump_nxt;
			cyc_mult_r <= cyc_mult_nxt;
			cyc_clr_r <= cyc_clr_nxt;
			feed_amt_r <= feed_amt_nxt;
			feed_spaces_r <= feed_spaces_nxt;
			feed_valid_r <= feed_valid_nxt;
			irq_r <= irq_nxt;
			fault_r <= fault_nxt;
			dl_run_r <= dl_run_nxt;
			dl_tick_r <= dl_tick_nxt;
			fw_cnt_r <= fw_cnt_nxt;
			field_stb_r <= field_stb_nxt;
			field_data_r <= field_data_nxt;
		end
	end

	assign o_s_axi_awready = awready_r;
	assign o_s_axi_wready = wready_r;
	assign o_s_axi_bvalid = bvalid_r;
	assign o_s_axi_bresp = bresp_r;
	assign o_s_axi_arready = arready_r;
	assign o_s_axi_rvalid = rvalid_r;
	assign o_s_axi_rresp = rresp_r;
	assign o_s_axi_rdata = rdata_r;
	assign o_row_irq = irq_r;
	assign o_feed_valid = feed_valid_r;
	assign o_feed_spaces = feed_spaces_r;
	assign o_field_valid = field_stb_r;
	assign o_field_data = field_data_r;
	assign o_fault = fault_r;
	assign o_busy = sq.active;
	assign o_fmt_count = cnt_r;

	AST_ROW_IRQ: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		o_row_irq |-> ($past(sq.pt_start) && $past(sq.pt_idx) <= LAST_ROW_PT && $past(cyc_irq_r)))
		else $error("row interrupt outside a row point start");
	AST_IRQ_SWITCH: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		(start_r && cyc_print_r && irq_sw_s) |-> ##2 o_row_irq)
		else $error("interrupt switch did not raise the first row interrupt");
	AST_JUMP_NINE: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		(sq.pt_start && sq.pt_idx == FIRST_PT && cyc_jump_r) |=> (o_feed_spaces == JUMP_SPACES))
		else $error("jump cycle did not feed nine spaces");
	AST_MULT_FEED: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		(sq.pt_start && sq.pt_idx == FIRST_PT && cyc_mult_r)
		|=> (o_feed_valid && o_feed_spaces == 3 * $past(feed_amt_r) / 3 && o_feed_spaces % 3 == 0))
		else $error("multiplied feed not a multiple of three");
	AST_CLEAR_NOFEED: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		(sq.pt_start && sq.pt_idx == FIRST_PT && cyc_clr_r) |=> (o_feed_spaces == 4'h0))
		else $error("clear position fed paper");
	AST_HOME_HOLD: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		(mode_r == MD_FMT && cnt_r == HOME_POS && !sq.active && !start_r && !fault_r)
		|=> (mode_r == MD_HOST && !start_r))
		else $error("home position did not hold");
	AST_CLR_HOME: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		sq.clr_hold |=> (cnt_r == HOME_POS && mode_r == MD_HOST))
		else $error("clear control did not return count home");
	AST_FW_FAULT: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		(dl_expire && !fw_evt) |=> (fault_r && !dl_run_r))
		else $error("missing field write not flagged");
	AST_WR_RESP: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		do_wr |=> (bvalid_r && !aw_have_r && !w_have_r))
		else $error("write not answered one cycle later");
endmodule

// >>> lpfc_host_model.sv
// Host model: queued AXI4-Lite write master that answers row interrupts
`timescale 1ns/1ps
module lpfc_host_model (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic i_row_irq,
	input wire logic i_auto,
	input wire logic i_req,
	input wire logic [39:0] i_cmd,
	input wire logic i_awready,
	input wire logic i_wready,
	input wire logic i_bvalid,
	output logic [7:0] o_awaddr,
	output logic o_awvalid,
	output logic [31:0] o_wdata,
	output logic o_wvalid,
	output logic o_idle
);
	import lpfc_pkg::*;
	logic [39:0] q[$];
	logic act;
	logic [31:0] n;
	always @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			q.delete();
			act = 1'b0;
			n = 32'h0;
			o_awvalid <= 1'b0;
			o_wvalid <= 1'b0;
			o_awaddr <= 8'h0;
			o_wdata <= 32'h0;
			o_idle <= 1'b1;
		end else begin
			if (i_req)
				q.push_back(i_cmd);
			// Field writes queue at once, well inside the deadline
			if (i_row_irq && i_auto) begin
				for (int k = 0; k < 3; k++) begin
					q.push_back({REG_FIELD, n});
					n = n + 32'h1;
				end
			end
			if (act) begin
				// Released lines show the inverse so a late sample is caught
				if (o_awvalid && i_awready) begin
					o_awvalid <= 1'b0;
					o_awaddr <= ~o_awaddr;
				end
				if (o_wvalid && i_wready) begin
					o_wvalid <= 1'b0;
					o_wdata <= ~o_wdata;
				end
				if (i_bvalid)
					act = 1'b0;
			end else if (q.size() != 0) begin
				{o_awaddr, o_wdata} <= q.pop_front();
				o_awvalid <= 1'b1;
				o_wvalid <= 1'b1;
				act = 1'b1;
			end
			o_idle <= !act && q.size() == 0;
		end
	end
endmodule

// >>> test_line_printer_format_control.sv
// Self-checking bench: printer cycles, row interrupts and format spacing
`timescale 1ns/1ps
module test_line_printer_format_control;
	import lpfc_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic awvalid, wvalid, awready, wready, bvalid, arready, rvalid, arvalid = 1'b0;
	logic rready = 1'b0;
	logic [7:0] awaddr, araddr = 8'h0;
	logic [31:0] wdata, rdata, fld;
	logic [1:0] bresp, rresp;
	logic [19:0] ctl = 20'h00095, spc = 20'h0007a;
	logic [9:0] mult = 10'h004;
	logic irq_sw = 1'b0, clr = 1'b0, req = 1'b0, auto = 1'b1;
	logic irq, fv, fldv, fault, busy, idle;
	logic [3:0] fsp, cnt;
	logic [39:0] cmd = 40'h0;
	logic [3:0] feeds[$];
	logic [31:0] los[5] = '{32'hc00, 32'h400, 32'h800, 32'h2000, 32'he00};
	logic [3:0] exp_sp[5] = '{4'h2, 4'h2, 4'h2, 4'h9, 4'h0};
	int exp_irq[5] = '{11, 11, 0, 0, 11};
	int err_count = 0, cmp_count = 0, nirq = 0;

	always #25 clk = ~clk;
	always @(posedge clk) begin
		if (irq)
			nirq++;
		if (fv)
			feeds.push_back(fsp);
	end

	lpfc_top #(.POINT_CYC_P(40), .FW_DEADLINE_CYC_P(10), .CLR_HOLD_CYC_P(8)) uut (
		.i_mclk(clk), .i_rst_b(rst_b), .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
		.o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hf),
		.i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
		.o_s_axi_bvalid(bvalid), .i_s_axi_bready(1'b1), .i_s_axi_araddr(araddr),
		.i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
		.o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
		.i_fmt_ctl(ctl), .i_fmt_space(spc), .i_fmt_mult(mult), .i_irq_switch(irq_sw),
		.i_clear_ctl(clr), .o_row_irq(irq), .o_feed_valid(fv), .o_feed_spaces(fsp),
		.o_field_valid(fldv), .o_field_data(fld), .o_fault(fault), .o_busy(busy),
		.o_fmt_count(cnt));

	lpfc_host_model hm (.i_mclk(clk), .i_rst_b(rst_b), .i_row_irq(irq), .i_auto(auto),
		.i_req(req), .i_cmd(cmd), .i_awready(awready), .i_wready(wready), .i_bvalid(bvalid),
		.o_awaddr(awaddr), .o_awvalid(awvalid), .o_wdata(wdata), .o_wvalid(wvalid),
		.o_idle(idle));

	task finish_test;
		$display("compares %0d errors %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task hang;
		err_count++;
		$display("unexpected at %0t: wait ran out", $time);
		finish_test;
	endtask

	// Writes go through the host model so they never collide with field writes
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int i = 0;
		cmd <= {a, d};
		req <= 1'b1;
		@(posedge clk);
		req <= 1'b0;
		repeat (2) @(posedge clk);
		while (idle !== 1'b1) begin
			@(posedge clk);
			if (++i > 200)
				hang;
		end
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int i = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (++i > 100)
				hang;
		end while (arready !== 1'b1);
		arvalid <= 1'b0;
		do begin
			@(posedge clk);
			if (++i > 200)
				hang;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		// Let an edge pass so back-to-back reads never drive rready twice at once
		rready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic run(input logic [31:0] lo, input int n);
		int i = 0;
		feeds.delete();
		nirq = 0;
		wr(REG_FUNC_LO, lo);
		while (feeds.size() < n || busy !== 1'b0) begin
			@(posedge clk);
			if (++i > 1000 * n)
				hang;
		end
	endtask

	task automatic fmt_run(input logic [31:0] lo, input logic [3:0] e);
		run(lo, 4);
		check(32'(feeds[0]), 32'(e));
		check(32'(feeds[1]), 32'(e));
		check(32'(feeds[2]), 32'h9);
		check(32'(feeds[3]), 32'h0);
		check(32'(cnt), 32'h4);
	endtask

	task automatic press(input int n);
		clr <= 1'b1;
		repeat (n) @(posedge clk);
		clr <= 1'b0;
		repeat (10) @(posedge clk);
	endtask

	// Advance then clear positions all the way round must stop at home
	task automatic fmt_wrap;
		press(12);
		ctl <= 20'haaaa5;
		run(32'h1000, 10);
		check(32'(feeds[1]), 32'h2);
		check(32'(feeds[9]), 32'h0);
		check(32'(cnt), 32'h0);
	endtask

	// Next start word issued during point 11 starts a new cycle two clocks after the cycle end
	task automatic cont;
		int i = 0;
		int gap = 0;
		logic [31:0] d;
		logic [1:0] r;
		feeds.delete();
		nirq = 0;
		wr(REG_FUNC_LO, 32'hc00);
		do begin
			rd(REG_STATUS, d, r);
			if (++i > 200)
				hang;
		end while (d[ST_PT_LSB +: 4] != 4'hb);
		wr(REG_FUNC_LO, 32'hc00);
		i = 0;
		while (feeds.size() < 2 || busy !== 1'b0) begin
			@(posedge clk);
			if (feeds.size() == 1 && busy === 1'b0)
				gap++;
			if (++i > 2000)
				hang;
		end
		check(gap, 2);
		check(nirq, 22);
		check(32'(fault), 32'h0);
	endtask

	initial begin
		logic [31:0] d;
		logic [1:0] r;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		rd(REG_STATUS, d, r);
		check(d, 32'h0);
		check(32'(r), 32'(RESP_OKAY));
		rd(8'h10, d, r);
		check(32'(r), 32'(RESP_SLVERR));
		wr(REG_FUNC_HI, 32'h4);
		for (int k = 0; k < 5; k++) begin
			irq_sw <= (k == 1);
			run(los[k], 1);
			check(32'(feeds[0]), 32'(exp_sp[k]));
			check(nirq, exp_irq[k]);
			check(32'(cnt), 32'h0);
			check(32'(fault), 32'h0);
		end
		fmt_run(32'h1000, 4'h2);
		// A short press must not count as a clear
		press(3);
		check(32'(cnt), 32'h4);
		press(12);
		check(32'(cnt), 32'h0);
		fmt_run(32'h1200, 4'h0);
		fmt_wrap;
		cont;
		auto <= 1'b0;
		run(32'h400, 1);
		check(32'(fault), 32'h1);
		wr(REG_FUNC_LO, 32'h400);
		repeat (20) @(posedge clk);
		check(32'(busy), 32'h0);
		rd(REG_STATUS, d, r);
		check(32'(d[1]), 32'h1);
		finish_test;
	end
endmodule
